// ===== design/dex_regs.svh
`ifndef DEX_REGS_SVH
`define DEX_REGS_SVH

// ----------------------------------------------------------------
// instruction word layout (14-bit word)
// ----------------------------------------------------------------
`define DEX_INSTR_W 14
`define DEX_OPC_MSB 13
`define DEX_OPC_LSB 8
`define DEX_DEST_BIT 7
`define DEX_FILE_MSB 6
`define DEX_FILE_LSB 0
`define DEX_LIT_MSB 10
`define DEX_LIT_LSB 0
`define DEX_BR_MSB 13
`define DEX_BR_LSB 11

// ----------------------------------------------------------------
// opcode field values
// ----------------------------------------------------------------
`define DEX_OPC_DEC 6'h03
`define DEX_OPC_CLEAR_ACCUMULATOR_OP 6'h01
`define DEX_OPC_DECSZ 6'h0b
`define DEX_OPC_INCSZ 6'h0f
`define DEX_BR_TAG 3'h5

// ----------------------------------------------------------------
// upper pc latch bits that feed pc[14:11]
// ----------------------------------------------------------------
`define DEX_LATCH_MSB 6
`define DEX_LATCH_LSB 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DEX_ACC_RST 8'h00
`define DEX_ZERO_RST 1'b0
`define DEX_PC_RST 15'h0000
`define DEX_ADDR_RST 7'h00

`endif

// ===== design/dex_pkg.sv
package dex_pkg;

  // decoded operation of the current instruction
  typedef enum logic [2:0] {
    DEX_OP_NONE   = 3'h0,
    DEX_OP_DEC    = 3'h1,
    DEX_OP_CLEAR_ACCUMULATOR_OP   = 3'h2,
    DEX_OP_DECSZ  = 3'h3,
    DEX_OP_INCSZ  = 3'h4,
    DEX_OP_BRANCH = 3'h5
  } dex_op_e;

  // sequencer: ready, or swallowing the slot after a two-cycle op
  typedef enum logic [1:0] {
    DEX_ST_READY = 2'h0,
    DEX_ST_FLUSH = 2'h1
  } dex_state_e;

  // write-back into the file register space
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } dex_file_wr_s;

  // program counter load request
  typedef struct packed {
    logic en;
    logic [14:0] target;
  } dex_pc_load_s;

endpackage

// ===== design/dex_core.sv
`timescale 1ns/1ps
`include "dex_regs.svh"

// What this block does
// - decrement-file subtracts one from file register; destination 0 writes accumulator.
// - decrement-file with destination 1 writes result back into the same file.
// - clear-accumulator loads zero into accumulator and sets the zero flag.
// - decrement-and-skip routes result per destination bit, leaves flags untouched.
// - decrement-and-skip with zero result replaces next instruction with a no-op.
// - increment-and-skip routes result per destination bit, leaves flags untouched.
// - increment-and-skip with zero result replaces next instruction with a no-op.
// - branch loads its 11-bit literal into pc bits 10 to 0.
// - branch fills pc bits 14 to 11 from upper latch bits 6 to 3.
// - branch takes two cycles and changes no status flag.
module dex_core #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7,
  parameter int PC_W = 15
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction stream from fetch
  input wire logic instr_valid,
  input wire logic [`DEX_INSTR_W-1:0] instr,
  input wire logic [DATA_W-1:0] file_rd_data,
  input wire logic [6:0] upper_pc_latch,
  output logic instr_ready,
  // results towards file space, status and fetch
  output dex_pkg::dex_file_wr_s file_wr,
  output logic [DATA_W-1:0] acc,
  output logic zero_flag,
  output dex_pkg::dex_pc_load_s pc_load,
  output logic skip_next
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the carriers are fixed at the documented widths
  if (DATA_W != 8 || ADDR_W != 7 || PC_W != 15) begin : g_bad_width
    $error("dex_core: only 8-bit data, 7-bit address, 15-bit pc supported");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // step a file value by one in either direction, wrapping at 8 bits
  function automatic logic [7:0] step_val(input logic [7:0] v, input logic up);
    step_val = up ? 8'(v + 8'h01) : 8'(v - 8'h01);
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  dex_pkg::dex_state_e state_q;
  dex_pkg::dex_state_e state_d;
  logic ready_q;
  logic [5:0] opc_w;
  logic dest_w;
  logic [6:0] faddr_w;
  logic [10:0] lit_w;
  logic is_branch_w;
  dex_pkg::dex_op_e op_w;
  logic take_w;

  // field split; clear-accumulator shares its opcode field with a
  // file clear, so destination bit 0 tells them apart
  assign opc_w = instr[`DEX_OPC_MSB:`DEX_OPC_LSB];
  assign dest_w = instr[`DEX_DEST_BIT];
  assign faddr_w = instr[`DEX_FILE_MSB:`DEX_FILE_LSB];
  assign lit_w = instr[`DEX_LIT_MSB:`DEX_LIT_LSB];
  assign is_branch_w = (instr[`DEX_BR_MSB:`DEX_BR_LSB] == `DEX_BR_TAG);
  assign op_w = is_branch_w ? dex_pkg::DEX_OP_BRANCH :
                (opc_w == `DEX_OPC_DEC) ? dex_pkg::DEX_OP_DEC :
                (opc_w == `DEX_OPC_CLEAR_ACCUMULATOR_OP && !dest_w) ? dex_pkg::DEX_OP_CLEAR_ACCUMULATOR_OP :
                (opc_w == `DEX_OPC_DECSZ) ? dex_pkg::DEX_OP_DECSZ :
                (opc_w == `DEX_OPC_INCSZ) ? dex_pkg::DEX_OP_INCSZ :
                dex_pkg::DEX_OP_NONE;

  // an instruction offered during a flush slot is the swallowed one
  assign take_w = instr_valid && ready_q;

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  logic is_dec_w;
  logic is_clear_accumulator_op_w;
  logic is_skip_w;
  logic is_file_op_w;
  logic [7:0] res_w;
  logic res_zero_w;

  // operation class and the single adder result
  assign is_dec_w = take_w && (op_w == dex_pkg::DEX_OP_DEC);
  assign is_clear_accumulator_op_w = take_w && (op_w == dex_pkg::DEX_OP_CLEAR_ACCUMULATOR_OP);
  assign is_skip_w = take_w && (op_w == dex_pkg::DEX_OP_DECSZ || op_w == dex_pkg::DEX_OP_INCSZ);
  assign is_file_op_w = is_dec_w || is_skip_w;
  assign res_w = step_val(file_rd_data, op_w == dex_pkg::DEX_OP_INCSZ);
  assign res_zero_w = (res_w == 8'h00);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // branch and a taken skip both cost one extra slot
  always_comb begin
    case (state_q)
      dex_pkg::DEX_ST_READY: begin
        if (take_w && (op_w == dex_pkg::DEX_OP_BRANCH || (is_skip_w && res_zero_w))) begin
          state_d = dex_pkg::DEX_ST_FLUSH;
        end else begin
          state_d = dex_pkg::DEX_ST_READY;
        end
      end
      dex_pkg::DEX_ST_FLUSH: state_d = dex_pkg::DEX_ST_READY;
      default: state_d = dex_pkg::DEX_ST_READY;
    endcase
  end

  // ready is registered so the port comes straight from a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= dex_pkg::DEX_ST_READY;
      ready_q <= 1'b1;
    end else begin
      state_q <= state_d;
      ready_q <= (state_d == dex_pkg::DEX_ST_READY);
    end
  end

  // ----------------------------------------------------------------
  // file write-back
  // ----------------------------------------------------------------
  dex_pkg::dex_file_wr_s file_wr_q;

  // a one-cycle strobe; address and data hold until the next decrement or skip op
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      file_wr_q <= '{en: 1'b0, addr: `DEX_ADDR_RST, data: `DEX_ACC_RST};
    end else begin
      file_wr_q.en <= is_file_op_w && dest_w;
      if (is_file_op_w) begin
        file_wr_q.addr <= faddr_w;
        file_wr_q.data <= res_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // accumulator and zero flag
  // ----------------------------------------------------------------
  logic [7:0] acc_q;
  logic zero_q;

  // only the plain decrement and the clear touch the flag; the skip
  // forms and the branch leave it alone so loops keep their status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q <= `DEX_ACC_RST;
      zero_q <= `DEX_ZERO_RST;
    end else begin
      if (is_clear_accumulator_op_w) begin
        acc_q <= 8'h00;
        zero_q <= 1'b1;
      end else begin
        if (is_file_op_w && !dest_w) begin
          acc_q <= res_w;
        end
        if (is_dec_w) begin
          zero_q <= res_zero_w;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // program counter load and skip strobe
  // ----------------------------------------------------------------
  dex_pkg::dex_pc_load_s pc_load_q;
  logic skip_q;

  // target = latch bits 6:3 over the 11-bit literal
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_load_q <= '{en: 1'b0, target: `DEX_PC_RST};
      skip_q <= 1'b0;
    end else begin
      pc_load_q.en <= take_w && (op_w == dex_pkg::DEX_OP_BRANCH);
      if (take_w && op_w == dex_pkg::DEX_OP_BRANCH) begin
        pc_load_q.target <= {upper_pc_latch[`DEX_LATCH_MSB:`DEX_LATCH_LSB], lit_w};
      end
      skip_q <= is_skip_w && res_zero_w;
    end
  end

  // outputs
  assign instr_ready = ready_q;
  assign file_wr = file_wr_q;
  assign acc = acc_q;
  assign zero_flag = zero_q;
  assign pc_load = pc_load_q;
  assign skip_next = skip_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // one swallowed slot, then ready again
  sequence s_flush;
    !ready_q ##1 ready_q;
  endsequence

  sequence s_no_flush;
    ready_q && !skip_q;
  endsequence

  dec_to_acc_a: assert property (
    is_dec_w && !dest_w |=> acc_q == $past(file_rd_data) - 8'h01 && !file_wr_q.en)
    else $error("decrement to accumulator wrong");

  dec_to_file_a: assert property (
    is_dec_w && dest_w |=> file_wr_q.en && file_wr_q.addr == $past(faddr_w)
      && file_wr_q.data == $past(file_rd_data) - 8'h01 && $stable(acc_q))
    else $error("decrement write-back wrong");

  clear_acc_a: assert property (
    is_clear_accumulator_op_w |=> acc_q == 8'h00 && zero_q && !file_wr_q.en)
    else $error("clear accumulator wrong");

  dec_skip_flags_a: assert property (
    is_skip_w && op_w == dex_pkg::DEX_OP_DECSZ |=> $stable(zero_q)
      && (file_wr_q.en == $past(dest_w)) && file_wr_q.data == $past(file_rd_data) - 8'h01)
    else $error("decrement-skip changed flag or routed wrong");

  dec_skip_slot_a: assert property (
    is_skip_w && op_w == dex_pkg::DEX_OP_DECSZ && file_rd_data == 8'h01
      |=> skip_q ##0 s_flush)
    else $error("decrement-skip did not swallow next slot");

  inc_skip_flags_a: assert property (
    is_skip_w && op_w == dex_pkg::DEX_OP_INCSZ |=> $stable(zero_q)
      && file_wr_q.data == $past(file_rd_data) + 8'h01)
    else $error("increment-skip changed flag or result wrong");

  inc_skip_slot_a: assert property (
    is_skip_w && op_w == dex_pkg::DEX_OP_INCSZ && file_rd_data == 8'hff
      |=> skip_q ##0 s_flush)
    else $error("increment-skip did not swallow next slot");

  skip_nonzero_a: assert property (
    is_skip_w && !res_zero_w |=> s_no_flush)
    else $error("skip taken on nonzero result");

  branch_low_a: assert property (
    take_w && op_w == dex_pkg::DEX_OP_BRANCH |=> pc_load_q.en && pc_load_q.target[10:0] == $past(lit_w))
    else $error("branch literal not loaded");

  branch_high_a: assert property (
    take_w && op_w == dex_pkg::DEX_OP_BRANCH |=> pc_load_q.target[14:11] == $past(upper_pc_latch[6:3]))
    else $error("branch upper bits wrong");

  branch_timing_a: assert property (
    take_w && op_w == dex_pkg::DEX_OP_BRANCH |=> $stable(zero_q) ##0 s_flush)
    else $error("branch not two cycles or flag touched");

  dec_zero_a: assert property (
    is_dec_w |=> zero_q == ($past(file_rd_data) == 8'h01))
    else $error("decrement zero flag wrong");

  // ----------------------------------------------------------------
  // slot and routing guards
  // ----------------------------------------------------------------
  // the swallowed slot must leave every result untouched
  flush_quiet_a: assert property (
    !ready_q |=> !file_wr_q.en && !pc_load_q.en && !skip_q && $stable(acc_q) && $stable(zero_q))
    else $error("swallowed slot had an effect");

  skip_pulse_a: assert property (
    skip_q |=> !skip_q)
    else $error("skip strobe longer than one cycle");

  branch_pulse_a: assert property (
    pc_load_q.en |=> !pc_load_q.en)
    else $error("branch load strobe longer than one cycle");

  dec_skip_acc_a: assert property (
    is_skip_w && op_w == dex_pkg::DEX_OP_DECSZ && !dest_w |=> acc_q == $past(file_rd_data) - 8'h01)
    else $error("decrement-skip result not in accumulator");

  inc_skip_acc_a: assert property (
    is_skip_w && op_w == dex_pkg::DEX_OP_INCSZ && !dest_w |=> acc_q == $past(file_rd_data) + 8'h01
      && !file_wr_q.en)
    else $error("increment-skip result not in accumulator");

  skip_file_addr_a: assert property (
    is_skip_w && dest_w |=> file_wr_q.en && file_wr_q.addr == $past(faddr_w) && $stable(acc_q))
    else $error("skip write-back address wrong");

  // the file-clear form of the clear opcode is not decoded here, so it must do nothing
  undecoded_quiet_a: assert property (
    take_w && op_w == dex_pkg::DEX_OP_NONE |=> !file_wr_q.en && !pc_load_q.en && !skip_q
      && $stable(acc_q) && $stable(zero_q))
    else $error("undecoded word had an effect");

endmodule // dex_core

// ===== sim/testbench.sv
`timescale 1ns/1ps
`include "dex_regs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  // ------------------------------
  // stimulus and observed signals
  // ------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] file_rd_data = 8'h00;
  logic [6:0] upper_pc_latch = 7'h00;
  logic instr_ready;
  dex_pkg::dex_file_wr_s file_wr;
  logic [7:0] acc;
  logic zero_flag;
  dex_pkg::dex_pc_load_s pc_load;
  logic skip_next;
  int mismatches = 0;
  int cmp_count = 0;
  int acc_m = 0;
  int zero_m = 0;
  logic [31:0] rng = 32'h0000_0031;

  // 100 ns period
  always #50 clk = ~clk;
  dex_core dex_core_inst (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .file_rd_data(file_rd_data), .upper_pc_latch(upper_pc_latch), .instr_ready(instr_ready),
    .file_wr(file_wr), .acc(acc), .zero_flag(zero_flag), .pc_load(pc_load), .skip_next(skip_next));

  // ------------------------------
  // helpers
  // ------------------------------
  // repeatable stream from the fixed seed
  function automatic logic [31:0] xorshift();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // offer one word, check it one cycle later against the model
  task automatic run(input logic [13:0] word, input logic [7:0] rd, input logic [6:0] lat);
    int r = 0;
    int sk = 0;
    int wr = 0;
    logic d = word[7];
    logic [31:0] w;
    `CHK(instr_ready, 1'b1)
    instr = word;
    file_rd_data = rd;
    upper_pc_latch = lat;
    instr_valid = 1'b1;
    @(negedge clk);
    if (word[13:11] == `DEX_BR_TAG) begin
      `CHK(pc_load.en, 1'b1)
      `CHK(pc_load.target[10:0], word[10:0])
      `CHK(pc_load.target[14:11], lat[6:3])
      `CHK(file_wr.en, 1'b0)
      `CHK(skip_next, 1'b0)
      sk = 1;
    end else begin
      `CHK(pc_load.en, 1'b0)
      case (word[13:8])
        `DEX_OPC_DEC: begin r = (int'(rd) - 1) & 255; wr = 1; zero_m = (r == 0); end
        `DEX_OPC_DECSZ: begin r = (int'(rd) - 1) & 255; wr = 1; sk = (r == 0); end
        `DEX_OPC_INCSZ: begin r = (int'(rd) + 1) & 255; wr = 1; sk = (r == 0); end
        `DEX_OPC_CLEAR_ACCUMULATOR_OP: if (!d) begin acc_m = 0; zero_m = 1; end
        default: ;
      endcase
      if (wr != 0 && !d) acc_m = r;
      `CHK(file_wr.en, (wr != 0) && d)
      if (wr != 0 && d) begin
        `CHK(file_wr.addr, word[6:0])
        `CHK(file_wr.data, r[7:0])
      end
      `CHK(skip_next, sk[0])
    end
    `CHK(acc, acc_m[7:0])
    `CHK(zero_flag, zero_m[0])
    `CHK(instr_ready, ~sk[0])
    if (sk != 0) begin
      // swallowed slot: the live word offered must have no effect
      w = xorshift();
      instr = w[13:0];
      file_rd_data = w[23:16];
      @(negedge clk);
      `CHK(file_wr.en, 1'b0)
      `CHK(pc_load.en, 1'b0)
      `CHK(acc, acc_m[7:0])
      `CHK(zero_flag, zero_m[0])
      `CHK(skip_next, 1'b0)
    end
  endtask
  task automatic check_reset();
    `CHK(acc, 8'h00)
    `CHK(zero_flag, 1'b0)
    `CHK(instr_ready, 1'b1)
    `CHK(file_wr.en, 1'b0)
    `CHK(pc_load.en, 1'b0)
    `CHK(skip_next, 1'b0)
  endtask

  // ------------------------------
  // run control
  // ------------------------------
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    results();
  end
  // main sequence
  initial begin
    logic [31:0] w;
    logic [5:0] opcs [8];
    logic [13:0] word;
    int i;
    opcs = '{`DEX_OPC_DEC, `DEX_OPC_CLEAR_ACCUMULATOR_OP, `DEX_OPC_DECSZ, `DEX_OPC_INCSZ, 6'h3f, 6'h00, 6'h00, 6'h00};
    repeat (20) @(negedge clk);
    check_reset();
    rst = 1'b0;
    for (i = 0; i < 10 && instr_ready !== 1'b1; i++) @(negedge clk);
    if (i == 10) begin
      mismatches++;
    end
    // directed corners, issued back to back
    run({`DEX_OPC_DEC, 1'b1, 7'h10}, 8'h05, 7'h00);
    run({`DEX_OPC_DEC, 1'b0, 7'h22}, 8'h01, 7'h00);
    run({`DEX_OPC_DEC, 1'b0, 7'h7f}, 8'h00, 7'h00);
    run({`DEX_OPC_CLEAR_ACCUMULATOR_OP, 1'b0, 7'h00}, 8'h55, 7'h00);
    run({`DEX_OPC_CLEAR_ACCUMULATOR_OP, 1'b1, 7'h12}, 8'h33, 7'h00);
    run({`DEX_OPC_DECSZ, 1'b0, 7'h01}, 8'h01, 7'h00);
    run({`DEX_OPC_DECSZ, 1'b1, 7'h7f}, 8'h02, 7'h00);
    run({`DEX_OPC_INCSZ, 1'b1, 7'h00}, 8'hff, 7'h00);
    run({`DEX_OPC_INCSZ, 1'b0, 7'h05}, 8'h7f, 7'h00);
    run({3'h5, 11'h123}, 8'h00, 7'h78);
    run({3'h5, 11'h7ff}, 8'h00, 7'h07);
    run({3'h5, 11'h000}, 8'h00, 7'h7f);
    // random mix, wrap values favoured
    for (i = 0; i < 200; i++) begin
      w = xorshift();
      word = {opcs[w[2:0]], w[7], w[14:8]};
      if (w[2:0] >= 3'h5) begin
        word = {3'h5, w[18:8]};
      end
      run(word, w[20] ? ({7'h00, w[21]} ^ {8{w[22]}}) : w[31:24], w[30:24]);
    end
    // mid-run reset, accumulator nonzero
    run({`DEX_OPC_DEC, 1'b0, 7'h01}, 8'h00, 7'h00);
    rst = 1'b1;
    instr_valid = 1'b0;
    @(negedge clk);
    check_reset();
    acc_m = 0;
    zero_m = 0;
    rst = 1'b0;
    @(negedge clk);
    run({`DEX_OPC_DEC, 1'b0, 7'h33}, 8'h10, 7'h00);
    results();
  end
endmodule // testbench
